// ==== inc/fdchr_pkg.sv ====
// fdchr_pkg: offsets, field positions, reset values and timing
// constants of the diskette controller host register block.
// assumes a 100 MHz core clock and a 3-bit host i/o offset.
package fdchr_pkg;

	// host i/o offsets
	localparam logic [2:0] OFS_STAT_A = 3'h0;
	localparam logic [2:0] OFS_STAT_B = 3'h1;
	localparam logic [2:0] OFS_DOC    = 3'h2;
	localparam logic [2:0] OFS_TAPE   = 3'h3;
	localparam logic [2:0] OFS_MAIN   = 3'h4; // read main status, write rate
	localparam logic [2:0] OFS_QUEUE  = 3'h5;
	localparam logic [2:0] OFS_DIN    = 3'h7; // read input, write config

	// value of undriven bits on a read
	localparam logic [7:0] FLOAT_BYTE = 8'hFF;

	// reset values
	localparam logic [7:0] DOC_RESET     = 8'h00;
	localparam logic [1:0] TAPE_RESET    = 2'h0;
	localparam logic [1:0] RATE_RESET    = 2'h0;
	localparam logic [2:0] PRECOMP_RESET = 3'h0;

	// drive output control fields
	localparam int DOC_MOTOR_LSB = 4;
	localparam int DOC_DMA       = 3;
	localparam int DOC_NRST      = 2;
	localparam int DOC_SEL_LSB   = 0;

	// rate select write fields
	localparam int RSEL_SWRST   = 7;
	localparam int RSEL_LOWPWR  = 6;
	localparam int RSEL_PRE_LSB = 2;
	localparam int RATE_LSB     = 0;

	// first command byte
	localparam int             CMD_MFM_BIT = 6;
	localparam logic [4:0]     OPC_READ    = 5'h06;
	localparam logic [4:0]     OPC_WRITE   = 5'h05;
	localparam logic [1:0]     RATE_HIGH_DENS = 2'h0;

	// bit cell timing per rate code, mfm cells; fm cells are twice as long
	localparam int CLK_NS    = 10;
	localparam int CELL_W    = 10;
	localparam int CELL_NS_0 = 2000; // 500 kb/s
	localparam int CELL_NS_1 = 3333; // 300 kb/s
	localparam int CELL_NS_2 = 4000; // 250 kb/s
	localparam int CELL_NS_3 = 1000; // 1 Mb/s
	localparam logic [CELL_W-1:0] CELL_CYC_0 = CELL_W'(CELL_NS_0 / CLK_NS);
	localparam logic [CELL_W-1:0] CELL_CYC_1 = CELL_W'(CELL_NS_1 / CLK_NS);
	localparam logic [CELL_W-1:0] CELL_CYC_2 = CELL_W'(CELL_NS_2 / CLK_NS);
	localparam logic [CELL_W-1:0] CELL_CYC_3 = CELL_W'(CELL_NS_3 / CLK_NS);

	// command phase as seen from the host queue
	typedef enum logic [0:0] {
		CMD_IDLE,
		CMD_PARAM
	} fdchr_cmd_ph_t;

endpackage : fdchr_pkg

// ==== rtl/fdchr_buf.sv ====
// fdchr_buf: two-entry buffer with valid/ready on both sides.
// assumes single clock; the drain side may stall at any time.
`timescale 1ns/100ps
module fdchr_buf #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             reset_n_i,
	// fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// drain side
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic                  rp;
		logic [1:0]            cnt;
	} fdchr_buf_st_t;

	fdchr_buf_st_t q, d;
	logic          push, pop;

	// handshakes; full and empty follow the count
	assign in_ready_o  = (q.cnt != 2'h2);
	assign out_valid_o = (q.cnt != 2'h0);
	assign out_data_o  = q.mem[q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// next state
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.rp ^ q.cnt[0]] = in_data_i;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	buf_full_c: cover property (@(posedge core_clk_i) q.cnt == 2'h2);

endmodule : fdchr_buf

// ==== rtl/fdchr_sep.sv ====
// fdchr_sep: digital data separator; recentres its cell phase on each
// read pulse and emits one recovered bit per cell.
// assumes the raw read line is synchronous to the core clock.
`timescale 1ns/100ps
module fdchr_sep
	import fdchr_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              reset_n_i,
	// raw read line and cell length
	input  wire logic              rd_raw_i,
	input  wire logic [CELL_W-1:0] cell_cyc_i,
	// recovered bits
	output logic                   bit_o,
	output logic                   bit_valid_o
);
	typedef struct packed {
		logic [CELL_W-1:0] cnt;
		logic              prev;
		logic              seen;
		logic              bit_v;
		logic              vld;
	} fdchr_sep_st_t;

	fdchr_sep_st_t q, d;
	logic          pulse;

	assign pulse       = rd_raw_i && !q.prev;
	assign bit_o       = q.bit_v;
	assign bit_valid_o = q.vld;

	// cell counter, pulse capture and phase pull
	always_comb begin
		d      = q;
		d.prev = rd_raw_i;
		d.vld  = 1'b0;
		if (q.cnt >= cell_cyc_i - CELL_W'(1)) begin
			d.cnt   = '0;
			d.bit_v = q.seen;
			d.vld   = 1'b1;
			d.seen  = 1'b0;
		end else begin
			d.cnt = CELL_W'(q.cnt + CELL_W'(1));
		end
		if (pulse) begin
			d.seen = 1'b1;
			d.cnt  = cell_cyc_i >> 1;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	sep_spacing_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i) q.vld |=> !q.vld)
		else $error("separator emitted two bits in adjacent cycles");

	sep_bit_c: cover property (@(posedge core_clk_i) q.vld && q.bit_v);

endmodule : fdchr_sep

// ==== rtl/fdchr_regs.sv ====
// fdchr_regs: host register block of the diskette controller.
// assumes host i/o strobes are one-cycle pulses, synchronous to the
// core clock, and that a command sequencer drains the data queue.
// mode straps are levels, changed only between host accesses.
`timescale 1ns/100ps

// Overview of operation
// - first read/write command byte bit 6 picks fm (0) or mfm (1)
// - no media sensing; density comes from the rate, not drive pins
// - only the lower data-rate line is driven toward the drive
// - undriven register bits read as one
// - 04h reads main status, writes rate; 07h reads input, writes config
// - legacy and alternate system modes; shared fields valid in both
// - status registers at 00h and 01h exist only in alternate mode
// - extended tape mode adds drive-change bits at offset 03h
// - legacy mode input register: disk change in bit 7, rest reserved
// - alternate mode input register: change, rate status, high density
// - tape register holds a two-bit select in bits 1 and 0
// - read data recovered by an on-chip digital separator
module fdchr_regs
	import fdchr_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// host i/o port
	input  wire logic [2:0] io_addr_i,
	input  wire logic       io_rd_i,
	input  wire logic       io_wr_i,
	input  wire logic [7:0] io_wdata_i,
	output logic      [7:0] io_rdata_o,
	// mode straps
	input  wire logic       alt_mode_i,
	input  wire logic       ext_tape_mode_i,
	// command byte stream toward the sequencer
	output logic      [7:0] cmd_data_o,
	output logic            cmd_valid_o,
	input  wire logic       cmd_ready_i,
	input  wire logic       cmd_done_i,
	output logic            mfm_mode_o,
	// result byte stream from the sequencer
	input  wire logic [7:0] res_data_i,
	input  wire logic       res_valid_i,
	output logic            res_ready_o,
	// sequencer status
	input  wire logic       non_dma_exec_i,
	input  wire logic [3:0] drive_busy_i,
	// drive interface status
	input  wire logic       irq_pending_i,
	input  wire logic       step_i,
	input  wire logic       trk0_i,
	input  wire logic       head_sel_i,
	input  wire logic       index_i,
	input  wire logic       wp_i,
	input  wire logic       head_dir_i,
	input  wire logic       wdata_i,
	input  wire logic       wgate_i,
	input  wire logic       disk_change_i,
	input  wire logic [1:0] drive_change_i,
	input  wire logic       rd_raw_i,
	// drive controls
	output logic      [1:0] drive_sel_o,
	output logic      [3:0] motor_en_o,
	output logic            dma_en_o,
	output logic            ctrl_reset_n_o,
	output logic            soft_reset_o,
	output logic            low_power_o,
	output logic      [2:0] precomp_o,
	output logic            rate_lo_o,
	output logic      [1:0] tape_sel_o,
	// recovered read data
	output logic            sep_bit_o,
	output logic            sep_bit_valid_o
);
	typedef struct packed {
		logic [7:0]    doc;
		logic [1:0]    tape;
		logic [1:0]    rate;
		logic [2:0]    precomp;
		logic          low_power;
		logic          soft_rst;
		logic          mfm;
		fdchr_cmd_ph_t ph;
		logic [7:0]    rdata;
	} fdchr_regs_st_t;

	fdchr_regs_st_t    q, d;
	logic              q_in_valid, q_in_ready;
	logic              cmd_take, first_rw;
	logic              dio, rqm, high_dens;
	logic [CELL_W-1:0] cell_mfm, cell_cyc;
	logic [7:0]        rd_val;

	// register-driven outputs
	assign drive_sel_o    = q.doc[DOC_SEL_LSB +: 2];
	assign motor_en_o     = q.doc[DOC_MOTOR_LSB +: 4];
	assign dma_en_o       = q.doc[DOC_DMA];
	assign ctrl_reset_n_o = q.doc[DOC_NRST];
	assign soft_reset_o   = q.soft_rst;
	assign low_power_o    = q.low_power;
	assign precomp_o      = q.precomp;
	assign tape_sel_o     = q.tape;
	assign mfm_mode_o     = q.mfm;
	assign io_rdata_o     = q.rdata;
	assign rate_lo_o      = q.rate[RATE_LSB];

	// data queue: host writes fill it, the sequencer drains it
	assign q_in_valid = io_wr_i && (io_addr_i == OFS_QUEUE);

	fdchr_buf #(
		.WIDTH(8)
	) u_queue (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.in_data_i   (io_wdata_i),
		.in_valid_i  (q_in_valid),
		.in_ready_o  (q_in_ready),
		.out_data_o  (cmd_data_o),
		.out_valid_o (cmd_valid_o),
		.out_ready_i (cmd_ready_i)
	);

	// cell length from rate; fm cells are twice as long
	always_comb begin
		unique case (q.rate)
			2'h0: cell_mfm = CELL_CYC_0;
			2'h1: cell_mfm = CELL_CYC_1;
			2'h2: cell_mfm = CELL_CYC_2;
			2'h3: cell_mfm = CELL_CYC_3;
		endcase
		cell_cyc = q.mfm ? cell_mfm : {cell_mfm[CELL_W-2:0], 1'b0};
	end

	// digital data separator on the raw read line
	fdchr_sep u_sep (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.rd_raw_i    (rd_raw_i),
		.cell_cyc_i  (cell_cyc),
		.bit_o       (sep_bit_o),
		.bit_valid_o (sep_bit_valid_o)
	);

	// queue snoop: first byte of a read or write command
	assign cmd_take = cmd_valid_o && cmd_ready_i;
	assign first_rw = cmd_take && (q.ph == CMD_IDLE) &&
		((cmd_data_o[4:0] == OPC_READ) || (cmd_data_o[4:0] == OPC_WRITE));

	// main status flags and density indication
	assign dio       = res_valid_i;
	assign rqm       = dio ? res_valid_i : q_in_ready;
	assign high_dens = (q.rate == RATE_HIGH_DENS);
	assign res_ready_o = io_rd_i && (io_addr_i == OFS_QUEUE) && res_valid_i;

	// read mux; undriven and reserved bits read as one
	always_comb begin
		unique case (io_addr_i)
			OFS_STAT_A: rd_val = alt_mode_i ?
				{irq_pending_i, 1'b1, step_i, trk0_i, head_sel_i,
				 index_i, wp_i, head_dir_i} : FLOAT_BYTE;
			OFS_STAT_B: rd_val = alt_mode_i ?
				{2'h3, q.doc[DOC_SEL_LSB], wdata_i, rd_raw_i, wgate_i,
				 q.doc[DOC_MOTOR_LSB +: 2]} : FLOAT_BYTE;
			OFS_DOC:    rd_val = q.doc;
			OFS_TAPE:   rd_val = ext_tape_mode_i ?
				{4'hF, drive_change_i, q.tape} : {6'h3F, q.tape};
			OFS_MAIN:   rd_val = {rqm, dio, non_dma_exec_i,
				(q.ph == CMD_PARAM), drive_busy_i};
			OFS_QUEUE:  rd_val = res_valid_i ? res_data_i : FLOAT_BYTE;
			OFS_DIN:    rd_val = alt_mode_i ?
				{disk_change_i, 4'hF, q.rate, high_dens} :
				{disk_change_i, 7'h7F};
			default:    rd_val = FLOAT_BYTE;
		endcase
	end

	// register writes, command phase, read capture
	always_comb begin
		d          = q;
		d.soft_rst = 1'b0;
		if (io_rd_i) begin
			d.rdata = rd_val;
		end
		if (first_rw) begin
			d.mfm = cmd_data_o[CMD_MFM_BIT];
		end
		if (cmd_take && (q.ph == CMD_IDLE)) begin
			d.ph = CMD_PARAM;
		end
		if (cmd_done_i) begin
			d.ph = CMD_IDLE;
		end
		// status offsets fall to the default arm and keep all state
		if (io_wr_i) begin
			unique case (io_addr_i)
				OFS_DOC:  d.doc  = io_wdata_i;
				OFS_TAPE: d.tape = io_wdata_i[1:0];
				OFS_MAIN: begin
					d.rate      = io_wdata_i[RATE_LSB +: 2];
					d.precomp   = io_wdata_i[RSEL_PRE_LSB +: 3];
					d.low_power = io_wdata_i[RSEL_LOWPWR];
					d.soft_rst  = io_wdata_i[RSEL_SWRST];
					if (io_wdata_i[RSEL_SWRST]) begin
						d.ph = CMD_IDLE;
					end
				end
				OFS_DIN:  d.rate = io_wdata_i[RATE_LSB +: 2];
				default:  d.rate = q.rate;
			endcase
		end
	end

	// state register; reset values come from the package
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q         <= '0;
			q.doc     <= DOC_RESET;
			q.tape    <= TAPE_RESET;
			q.rate    <= RATE_RESET;
			q.precomp <= PRECOMP_RESET;
			q.rdata   <= FLOAT_BYTE;
		end else begin
			q <= d;
		end
	end

	// checks on the host-visible behaviour
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	mfm_latch_a: assert property (first_rw |=>
		mfm_mode_o == $past(cmd_data_o[CMD_MFM_BIT]))
		else $error("encoding not taken from first command byte");
	rate_write_a: assert property (io_wr_i && (io_addr_i == OFS_MAIN)
		|=> rate_lo_o == $past(io_wdata_i[RATE_LSB]))
		else $error("rate write at 04h not reflected on rate line");
	cfg_write_a: assert property (io_wr_i && (io_addr_i == OFS_DIN)
		|=> rate_lo_o == $past(io_wdata_i[RATE_LSB]))
		else $error("config write at 07h not reflected on rate line");

	// read layouts
	float_read_a: assert property (io_rd_i && (io_addr_i == 3'h6)
		|=> io_rdata_o == FLOAT_BYTE)
		else $error("unmapped offset did not read all ones");
	legacy_stat_a: assert property (io_rd_i && !alt_mode_i &&
		(io_addr_i <= OFS_STAT_B) |=> io_rdata_o == FLOAT_BYTE)
		else $error("status register visible in legacy mode");
	legacy_din_a: assert property (io_rd_i && !alt_mode_i &&
		(io_addr_i == OFS_DIN) |=>
		io_rdata_o == {$past(disk_change_i), 7'h7F})
		else $error("legacy input register layout wrong");
	alt_din_a: assert property (io_rd_i && alt_mode_i &&
		(io_addr_i == OFS_DIN) |=> io_rdata_o[2:1] == $past(q.rate) &&
		io_rdata_o[0] == ($past(q.rate) == RATE_HIGH_DENS) &&
		io_rdata_o[7] == $past(disk_change_i))
		else $error("alternate input register layout wrong");
	tape_read_a: assert property (io_rd_i && !ext_tape_mode_i &&
		(io_addr_i == OFS_TAPE) |=>
		io_rdata_o == {6'h3F, $past(tape_sel_o)})
		else $error("tape register normal layout wrong");
	tape_ext_a: assert property (io_rd_i && ext_tape_mode_i &&
		(io_addr_i == OFS_TAPE) |=>
		io_rdata_o[3:2] == $past(drive_change_i) &&
		io_rdata_o[7:4] == 4'hF)
		else $error("drive-change bits missing in extended tape mode");

	// write protection and status
	ro_write_a: assert property (io_wr_i &&
		(io_addr_i <= OFS_STAT_B) && !first_rw |=>
		$stable(q.doc) && $stable(q.rate) && $stable(q.tape))
		else $error("write to read-only status changed state");
	main_busy_a: assert property (io_rd_i && (io_addr_i == OFS_MAIN)
		|=> io_rdata_o[4] == $past(q.ph == CMD_PARAM))
		else $error("command-in-progress bit wrong in main status");

	// further layouts, encoding hold and strobes
	mfm_hold_a: assert property (!first_rw |=>
		$stable(mfm_mode_o))
		else $error("encoding changed without a read or write command");
	doc_read_a: assert property (io_rd_i &&
		(io_addr_i == OFS_DOC) |=> io_rdata_o == $past(q.doc))
		else $error("output control readback wrong");
	stat_a_alt_a: assert property (io_rd_i && alt_mode_i &&
		(io_addr_i == OFS_STAT_A) |=> io_rdata_o[6] == 1'b1)
		else $error("reserved status a bit not read as one");
	stat_b_alt_a: assert property (io_rd_i && alt_mode_i &&
		(io_addr_i == OFS_STAT_B) |=> io_rdata_o[7:6] == 2'h3 &&
		io_rdata_o[1:0] == $past(motor_en_o[1:0]))
		else $error("status b layout wrong in alternate mode");
	queue_float_a: assert property (io_rd_i && !res_valid_i &&
		(io_addr_i == OFS_QUEUE) |=> io_rdata_o == FLOAT_BYTE)
		else $error("empty result port did not read all ones");
	main_rqm_a: assert property (io_rd_i &&
		(io_addr_i == OFS_MAIN) |=> io_rdata_o[7:6] ==
		($past(res_valid_i) ? 2'h3 : {$past(q_in_ready), 1'b0}))
		else $error("request and direction bits wrong in main status");
	soft_pulse_a: assert property (soft_reset_o &&
		!(io_wr_i && (io_addr_i == OFS_MAIN) && io_wdata_i[RSEL_SWRST])
		|=> !soft_reset_o)
		else $error("software reset held longer than one cycle");

	mfm_cmd_c: cover property (first_rw && cmd_data_o[CMD_MFM_BIT]);
	fm_cmd_c: cover property (first_rw && !cmd_data_o[CMD_MFM_BIT]);
	queue_stall_c: cover property (q_in_valid && !q_in_ready);

endmodule : fdchr_regs

// ==== verif/fdchr_drive_mdl.sv ====
// fdchr_drive_mdl: behavioural drive cable plus command sequencer.
// assumes the bench sets drive line patterns, stalls and results.
`timescale 1ns/100ps
module fdchr_drive_mdl (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// bench control
	input  wire logic [7:0] pat_i,
	input  wire logic       stall_i,
	input  wire logic       res_on_i,
	input  wire logic [7:0] res_byte_i,
	output logic      [7:0] taken_o,
	output logic      [7:0] last_o,
	// toward the register block
	input  wire logic [7:0] cmd_data_i,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	output logic            cmd_done_o,
	output logic      [7:0] res_data_o,
	output logic            res_valid_o,
	output logic      [7:0] stat_o
);
	// stall by level; stale result data shows its inverse
	assign cmd_ready_o = !stall_i;
	assign res_valid_o = res_on_i;
	assign res_data_o  = res_on_i ? res_byte_i : ~res_byte_i;
	assign stat_o      = pat_i;
	// count taken bytes, end each command one cycle after its byte
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			taken_o    <= 8'h00;
			last_o     <= 8'h00;
			cmd_done_o <= 1'b0;
		end else begin
			cmd_done_o <= cmd_valid_i && !stall_i;
			if (cmd_valid_i && !stall_i) begin
				taken_o <= taken_o + 8'h01;
				last_o  <= cmd_data_i;
			end
		end
	end
endmodule : fdchr_drive_mdl

// ==== verif/fdchr_regs_tb_top.sv ====
// fdchr_regs_tb_top: self-checking bench for the host register block.
// assumes a 100 MHz clock and one-cycle host strobes.
`timescale 1ns/100ps
module fdchr_regs_tb_top;
	import fdchr_pkg::*;
	logic       clk, reset_n, rd, wr, alt, ext, stall, res_on, found;
	logic [2:0] addr, precomp;
	logic [7:0] wdata, rdata, pat, res_byte, taken, last, cdata, rsd, stat;
	logic       cvalid, cready, cdone, mfm, rvalid, dma, nrst, srst, lowp;
	logic       rate_lo, sbit, sval, rrdy, popped;
	logic [1:0] dsel, tsel;
	logic [3:0] motor;
	logic [7:0] cmds [5] = '{8'h46, 8'h06, 8'h45, 8'h05, 8'h4A};
	logic       mfms [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int         fails, check_count;

	fdchr_regs u_fdchr_regs (.core_clk_i(clk), .reset_n_i(reset_n),
		.io_addr_i(addr), .io_rd_i(rd), .io_wr_i(wr), .io_wdata_i(wdata),
		.io_rdata_o(rdata), .alt_mode_i(alt), .ext_tape_mode_i(ext),
		.cmd_data_o(cdata), .cmd_valid_o(cvalid), .cmd_ready_i(cready),
		.cmd_done_i(cdone), .mfm_mode_o(mfm), .res_data_i(rsd),
		.res_valid_i(rvalid), .res_ready_o(rrdy), .non_dma_exec_i(stat[5]),
		.drive_busy_i(stat[3:0]), .irq_pending_i(stat[7]), .step_i(stat[5]),
		.trk0_i(stat[4]), .head_sel_i(stat[3]), .index_i(stat[2]),
		.wp_i(stat[1]), .head_dir_i(stat[0]), .wdata_i(stat[4]),
		.wgate_i(stat[2]), .disk_change_i(stat[7]),
		.drive_change_i(stat[3:2]), .rd_raw_i(stat[3]), .drive_sel_o(dsel),
		.motor_en_o(motor), .dma_en_o(dma), .ctrl_reset_n_o(nrst),
		.soft_reset_o(srst), .low_power_o(lowp), .precomp_o(precomp),
		.rate_lo_o(rate_lo), .tape_sel_o(tsel), .sep_bit_o(sbit),
		.sep_bit_valid_o(sval));

	fdchr_drive_mdl u_fdchr_drive_mdl (.core_clk_i(clk), .reset_n_i(reset_n),
		.pat_i(pat), .stall_i(stall), .res_on_i(res_on),
		.res_byte_i(res_byte), .taken_o(taken), .last_o(last),
		.cmd_data_i(cdata), .cmd_valid_i(cvalid), .cmd_ready_o(cready),
		.cmd_done_o(cdone), .res_data_o(rsd), .res_valid_o(rvalid),
		.stat_o(stat));

	// compare one value and count it
	task automatic chk(input string what, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one host write, returns just after the taking edge
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// one host read, compares the answer of the next cycle
	task automatic rd_reg(input logic [2:0] a, input string n,
		input logic [7:0] e);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		popped = rrdy;
		rd <= 1'b0;
		#1;
		chk(n, rdata, e);
	endtask : rd_reg

	// counts and verdict
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// main sequence
	initial begin
		{reset_n, rd, wr, alt, ext, stall, res_on} = '0;
		{addr, wdata} = '0;
		res_byte = 8'h3C;
		pat = 8'hA5;
		fails = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		#1;
		chk("rdata in reset", rdata, 8'hFF);
		chk("drive outputs in reset", {motor, dma, nrst, dsel}, DOC_RESET);
		@(posedge clk);
		reset_n <= 1'b1;
		// legacy mode layouts
		rd_reg(OFS_DIN, "input legacy set", 8'hFF);
		@(posedge clk);
		pat <= 8'h25;
		rd_reg(OFS_DIN, "input legacy clear", 8'h7F);
		rd_reg(OFS_STAT_A, "status a legacy", 8'hFF);
		rd_reg(OFS_STAT_B, "status b legacy", 8'hFF);
		rd_reg(3'h6, "reserved offset", 8'hFF);
		wr_reg(OFS_DOC, 8'hA5);
		chk("drive outputs", {motor, dma, nrst, dsel}, 8'hA5);
		// writes to read-only places change nothing
		wr_reg(OFS_STAT_A, 8'h00);
		wr_reg(OFS_STAT_B, 8'h00);
		wr_reg(3'h6, 8'h00);
		rd_reg(OFS_DOC, "output control", 8'hA5);
		chk("drive outputs kept", {motor, dma, nrst, dsel}, 8'hA5);
		// alternate mode layouts
		@(posedge clk);
		alt <= 1'b1;
		rd_reg(OFS_STAT_A, "status a alt", 8'h65);
		rd_reg(OFS_STAT_B, "status b alt", 8'hE6);
		rd_reg(OFS_DOC, "output control alt", 8'hA5);
		wr_reg(OFS_TAPE, 8'hFE);
		chk("tape select", {6'h00, tsel}, 8'h02);
		rd_reg(OFS_TAPE, "tape normal", 8'hFE);
		@(posedge clk);
		ext <= 1'b1;
		rd_reg(OFS_TAPE, "tape extended", 8'hF6);
		// shared offsets: read status, write rate
		rd_reg(OFS_MAIN, "main status idle", 8'hA5);
		wr_reg(OFS_MAIN, 8'h5D);
		chk("rate fields", {3'h0, lowp, precomp, rate_lo}, 8'h1F);
		rd_reg(OFS_MAIN, "main status kept", 8'hA5);
		rd_reg(OFS_DIN, "input alt", 8'h7A);
		for (int r = 0; r < 4; r++) begin
			wr_reg(OFS_DIN, 8'(r));
			chk("rate line", {7'h00, rate_lo}, 8'(r % 2));
			rd_reg(OFS_DIN, "input rate", {1'b0, 4'hF, 2'(r), r == 0});
		end
		// full queue refuses a third byte while the drain is stalled
		@(posedge clk);
		stall <= 1'b1;
		wr_reg(OFS_QUEUE, 8'h11);
		wr_reg(OFS_QUEUE, 8'h22);
		rd_reg(OFS_MAIN, "main status full", 8'h25);
		wr_reg(OFS_QUEUE, 8'h33);
		@(posedge clk);
		stall <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk("bytes taken", taken, 8'h02);
		chk("last byte", last, 8'h22);
		// encoding chosen by bit 6 of each first read or write command byte
		for (int i = 0; i < 5; i++) begin
			wr_reg(OFS_QUEUE, cmds[i]);
			rd_reg(OFS_MAIN, "main status busy", 8'hB5);
			repeat (3) @(posedge clk);
			#1;
			chk("encoding", {7'h00, mfm}, {7'h00, mfms[i]});
		end
		// result bytes, and floating bits when none waits
		@(posedge clk);
		res_on <= 1'b1;
		rd_reg(OFS_QUEUE, "result byte", 8'h3C);
		chk("result pop", {7'h00, popped}, 8'h01);
		rd_reg(OFS_MAIN, "main status result", 8'hE5);
		@(posedge clk);
		res_on <= 1'b0;
		rd_reg(OFS_QUEUE, "no result", 8'hFF);
		chk("no pop", {7'h00, popped}, 8'h00);
		// software reset pulse lasts one cycle
		wr_reg(OFS_MAIN, 8'h80);
		chk("soft reset high", {7'h00, srst}, 8'h01);
		@(posedge clk);
		#1;
		chk("soft reset low", {7'h00, srst}, 8'h00);
		// separator reports a pulse within a bounded number of cells
		wr_reg(OFS_DIN, 8'h03);
		@(posedge clk);
		pat <= 8'h2D;
		found = 1'b0;
		for (int i = 0; i < 1000 && !found; i++) begin
			@(posedge clk);
			#1;
			found = (sval === 1'b1) && (sbit === 1'b1);
		end
		chk("separated bit", {7'h00, found}, 8'h01);
		conclude();
	end
endmodule : fdchr_regs_tb_top
